// ===== logic/adc_fmt_ctrl.sv
// converter control: idle/reset handling, result formats, pin read-back
`include "adc_fmt_consts.svh"

// Notes on behaviour
// - With idle stop clear the converter runs on in CPU idle; set, it halts.
// - Reset restores all control registers, turns the converter off, aborts.
// - Reset leaves the stored results untouched.
// - Result storage is undefined after power-on.
// - Results and buffer entries are exactly 12 bits wide.
// - A buffer read always yields a 16-bit value shaped by the format.
// - Integer zero-extends, signed integer sign-extends, fractional shifts up.
// - Bus writes to the buffer are always taken as right-justified integer.
// - Port read returns 0 for every analog-configured pin.
// - A pin configured digital is not converted.
// - An analog pin set as output converts its driven digital level.
// - The sequence timing ignores channel select and direction settings.
module adc_fmt_ctrl #(
	parameter int NPINS = 16,
	parameter int DEPTH = 16,
	parameter int CONV_CYCLES = `CONV_TAD
)
(
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset
	input wire logic [7:0] awaddr, // write address
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // byte enables
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	output logic [1:0] bresp, // write response
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	input wire logic [7:0] araddr, // read address
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	input wire logic cpu_idle, // cpu in idle mode
	input wire logic [NPINS-1:0] pin_in, // digital pin levels
	input wire logic [NPINS-1:0] pin_out, // port output latch levels
	input wire logic [11:0] ana_code, // converter code of selected pin
	output logic conv_active // sequence running
);
	localparam int IW = $clog2(DEPTH);
	localparam int CW = $clog2(CONV_CYCLES + 1);
	localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (st[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction

	function automatic logic [15:0] shape(input logic [11:0] v,
		input adc_fmt_pkg::fmt_type f);
		case (f)
			adc_fmt_pkg::FMT_INT: shape = {4'h0, v};
			adc_fmt_pkg::FMT_SINT: shape = {{4{v[11]}}, v};
			default: shape = {v, 4'h0};
		endcase
	endfunction

	// ****************************************************************
	// bus and registers
	// ****************************************************************
	logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
	logic aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [7:0] waddr_q, waddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d, wm;
	logic [3:0] wstrb_q, wstrb_d;
	adc_fmt_pkg::ctrl_type ctrl_q, ctrl_d;
	adc_fmt_pkg::chsel_type chsel_q, chsel_d;
	logic [NPINS-1:0] pincfg_q, pincfg_d, dir_q, dir_d;
	logic start_q, start_d, done_clr, skip_clr, bus_we, commit;
	logic [11:0] buf_rd, buf_wr;
	logic [IW-1:0] buf_wa;
	logic done_q, skip_q, halted;
	adc_fmt_pkg::conv_state_type st_q;

	always_comb
	begin
		awready_d = 1'b0;
		wready_d = 1'b0;
		arready_d = 1'b0;
		aw_got_d = aw_got_q;
		w_got_d = w_got_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q & ~bready;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q & ~rready;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		ctrl_d = ctrl_q;
		chsel_d = chsel_q;
		pincfg_d = pincfg_q;
		dir_d = dir_q;
		start_d = 1'b0;
		done_clr = 1'b0;
		skip_clr = 1'b0;
		bus_we = 1'b0;
		wm = 32'h0;
		commit = aw_got_q & w_got_q & ~bvalid_q;
		if (awvalid & awready_q)
		begin
			aw_got_d = 1'b1;
			waddr_d = awaddr;
		end
		else if (awvalid & ~aw_got_q & ~awready_q)
			awready_d = 1'b1;
		if (wvalid & wready_q)
		begin
			w_got_d = 1'b1;
			wdata_d = wdata;
			wstrb_d = wstrb;
		end
		else if (wvalid & ~w_got_q & ~wready_q)
			wready_d = 1'b1;
		if (commit)
		begin
			aw_got_d = 1'b0;
			w_got_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = `RESP_OKAY;
			if (waddr_q[7:6] == `BUF_SEL)
				bus_we = 1'b1;
			else
				case (waddr_q)
				`CTRL_OFF:
				begin
					wm = merge({27'h0, 1'b0, ctrl_q}, wdata_q, wstrb_q);
					ctrl_d = adc_fmt_pkg::ctrl_type'(wm[3:0]);
					start_d = wm[`CTRL_START_BIT];
				end
				`STAT_OFF:
				begin
					done_clr = wstrb_q[0] & wdata_q[`STAT_DONE_BIT];
					skip_clr = wstrb_q[0] & wdata_q[`STAT_SKIP_BIT];
				end
				`CHSEL_OFF:
					if (wstrb_q[0])
						chsel_d = wdata_q[7:0];
				`PINCFG_OFF:
				begin
					wm = merge(32'(pincfg_q), wdata_q, wstrb_q);
					pincfg_d = wm[NPINS-1:0];
				end
				`DIR_OFF:
				begin
					wm = merge(32'(dir_q), wdata_q, wstrb_q);
					dir_d = wm[NPINS-1:0];
				end
				default: bresp_d = `RESP_SLVERR;
				endcase
		end
		if (arvalid & arready_q)
		begin
			rvalid_d = 1'b1;
			rresp_d = `RESP_OKAY;
			rdata_d = 32'h0;
			if (araddr[7:6] == `BUF_SEL)
				rdata_d = {16'h0, shape(buf_rd, ctrl_q.fmt)};
			else
				case (araddr)
				`CTRL_OFF: rdata_d = {28'h0, ctrl_q};
				`STAT_OFF: rdata_d = {28'h0, halted, skip_q, done_q,
					st_q == adc_fmt_pkg::ST_CONV};
				`CHSEL_OFF: rdata_d = {24'h0, chsel_q};
				`PINCFG_OFF: rdata_d = 32'(pincfg_q);
				`DIR_OFF: rdata_d = 32'(dir_q);
				`PORT_OFF: rdata_d = 32'(pin_in & pincfg_q);
				default: rresp_d = `RESP_SLVERR;
				endcase
		end
		else if (arvalid & ~rvalid_q & ~arready_q)
			arready_d = 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			arready_q <= 1'b0;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			waddr_q <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= `RESP_OKAY;
			rdata_q <= 32'h0;
			ctrl_q <= `CTRL_RST;
			chsel_q <= `CHSEL_RST;
			pincfg_q <= `PINCFG_RST;
			dir_q <= `DIR_RST;
			start_q <= 1'b0;
		end
		else
		begin
			awready_q <= awready_d;
			wready_q <= wready_d;
			arready_q <= arready_d;
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			ctrl_q <= ctrl_d;
			chsel_q <= chsel_d;
			pincfg_q <= pincfg_d;
			dir_q <= dir_d;
			start_q <= start_d;
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = rdata_q;

	// ****************************************************************
	// conversion sequence
	// ****************************************************************
	adc_fmt_pkg::conv_state_type st_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic [IW-1:0] ptr_q, ptr_d;
	logic done_d, skip_d, conv_we, act_q, act_d, last;
	logic [3:0] ch;
	logic [11:0] conv_res;

	assign halted = cpu_idle & ctrl_q.idle_stop;
	assign ch = chsel_q.sel_a;
	assign last = cnt_q == CONV_LAST;

	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		ptr_d = ptr_q;
		conv_we = 1'b0;
		done_d = done_q & ~done_clr;
		skip_d = skip_q & ~skip_clr;
		// input source only; timing below never looks at ch or dir
		if (!dir_q[ch])
			conv_res = {12{pin_out[ch]}};
		else
			conv_res = ana_code;
		case (st_q)
		adc_fmt_pkg::ST_IDLE:
			if (start_q & ctrl_q.on)
			begin
				st_d = adc_fmt_pkg::ST_CONV;
				cnt_d = '0;
			end
		adc_fmt_pkg::ST_CONV:
			if (!ctrl_q.on)
				st_d = adc_fmt_pkg::ST_IDLE;
			else if (!halted)
			begin
				cnt_d = cnt_q + CW'(1);
				if (last)
				begin
					st_d = adc_fmt_pkg::ST_IDLE;
					if (pincfg_q[ch])
						skip_d = 1'b1;
					else
					begin
						conv_we = 1'b1;
						ptr_d = ptr_q + IW'(1);
					end
					done_d = 1'b1;
				end
			end
		default: st_d = adc_fmt_pkg::ST_IDLE;
		endcase
		act_d = st_d == adc_fmt_pkg::ST_CONV;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_q <= adc_fmt_pkg::ST_IDLE;
			cnt_q <= '0;
			ptr_q <= '0;
			done_q <= 1'b0;
			skip_q <= 1'b0;
			act_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			ptr_q <= ptr_d;
			done_q <= done_d;
			skip_q <= skip_d;
			act_q <= act_d;
		end
	end

	assign conv_active = act_q;

	// conversion wins a collision; the bus write of that cycle is lost
	assign buf_wa = conv_we ? ptr_q : waddr_q[IW+1:2];
	assign buf_wr = conv_we ? conv_res : wdata_q[11:0];

	result_buffer #(.DEPTH(DEPTH), .W(12)) u_buf (
		.clk(aclk),
		.we(conv_we | bus_we),
		.waddr(buf_wa),
		.wdata(buf_wr),
		.raddr(araddr[IW+1:2]),
		.rdata(buf_rd)
	);

	// ****************************************************************
	// checks
	// ****************************************************************
	logic rd_buf_q, rd_port_q;
	adc_fmt_pkg::fmt_type rd_fmt_q;
	always_ff @(posedge aclk)
	begin
		rd_buf_q <= arvalid & arready_q & (araddr[7:6] == `BUF_SEL);
		rd_port_q <= arvalid & arready_q & (araddr == `PORT_OFF);
		rd_fmt_q <= ctrl_q.fmt;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	idle_halt_a: assert property ((st_q == adc_fmt_pkg::ST_CONV) && ctrl_q.on
		&& halted |=> $stable(cnt_q) && st_q == adc_fmt_pkg::ST_CONV)
		else $error("count moved while halted in idle");
	idle_run_a: assert property ((st_q == adc_fmt_pkg::ST_CONV) && ctrl_q.on
		&& cpu_idle && !ctrl_q.idle_stop && !last |=> cnt_q == $past(cnt_q) + 1)
		else $error("converter stopped in idle without idle stop");
	reset_off_a: assert property (disable iff (1'b0) !aresetn |=>
		ctrl_q == `CTRL_RST && st_q == adc_fmt_pkg::ST_IDLE && !conv_active)
		else $error("reset did not turn the converter off");
	abort_a: assert property ((st_q == adc_fmt_pkg::ST_CONV) && !ctrl_q.on
		|-> !conv_we ##1 st_q == adc_fmt_pkg::ST_IDLE)
		else $error("abort wrote a result");
	read_width_a: assert property (rd_buf_q |-> rdata_q[31:16] == 16'h0)
		else $error("buffer read wider than 16 bits");
	read_shape_a: assert property (rd_buf_q |->
		(rd_fmt_q == adc_fmt_pkg::FMT_INT ? rdata_q[15:12] == 4'h0 :
		rd_fmt_q == adc_fmt_pkg::FMT_SINT ? rdata_q[15:12] == {4{rdata_q[11]}} :
		rdata_q[3:0] == 4'h0))
		else $error("buffer read layout wrong");
	bus_write_a: assert property (bus_we && !conv_we |->
		buf_wr == wdata_q[11:0])
		else $error("bus write not right-justified");
	port_zero_a: assert property (rd_port_q |->
		(rdata_q[NPINS-1:0] & ~$past(pincfg_q)) == '0)
		else $error("analog pin read as one");
	digital_skip_a: assert property (st_q == adc_fmt_pkg::ST_CONV && last
		&& pincfg_q[ch] |-> !conv_we)
		else $error("digital pin converted");
	drive_out_a: assert property (conv_we && !dir_q[ch] |->
		buf_wr == {12{pin_out[ch]}})
		else $error("output pin level not converted");
	seq_len_a: assert property (st_q == adc_fmt_pkg::ST_CONV && last
		&& ctrl_q.on && !halted |=> st_q == adc_fmt_pkg::ST_IDLE && done_q)
		else $error("sequence length wrong");

	conv_done_c: cover property (conv_we ##1 done_q);
	idle_hold_c: cover property (st_q == adc_fmt_pkg::ST_CONV && halted);
	sint_read_c: cover property (rd_buf_q && rd_fmt_q == adc_fmt_pkg::FMT_SINT);
	abort_c: cover property (st_q == adc_fmt_pkg::ST_CONV && !ctrl_q.on);
endmodule

// ===== logic/adc_fmt_consts.svh
// register offsets, field positions, reset values and counts of the block
`ifndef ADC_FMT_CONSTS_SVH
`define ADC_FMT_CONSTS_SVH
`define ADDR_W 8
`define CTRL_OFF 8'h00
`define STAT_OFF 8'h04
`define CHSEL_OFF 8'h08
`define PINCFG_OFF 8'h0C
`define DIR_OFF 8'h10
`define PORT_OFF 8'h14
`define BUF_SEL 2'h1
`define CTRL_ON_BIT 0
`define CTRL_IDLE_BIT 1
`define CTRL_FMT_LSB 2
`define CTRL_START_BIT 4
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_SKIP_BIT 2
`define STAT_HALT_BIT 3
`define CTRL_RST 4'h0
`define CHSEL_RST 8'h00
`define PINCFG_RST 16'h0000
`define DIR_RST 16'hFFFF
`define CONV_TAD 14
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== logic/adc_fmt_pkg.sv
// types shared by the converter control block
package adc_fmt_pkg;
	typedef enum logic [1:0]
	{
		FMT_INT = 2'h0,
		FMT_SINT = 2'h1,
		FMT_FRAC = 2'h2,
		FMT_SFRAC = 2'h3
	} fmt_type;
	typedef struct packed
	{
		fmt_type fmt;
		logic idle_stop;
		logic on;
	} ctrl_type;
	typedef struct packed
	{
		logic [3:0] sel_b;
		logic [3:0] sel_a;
	} chsel_type;
	typedef enum {ST_IDLE, ST_CONV} conv_state_type;
endpackage

// ===== logic/result_buffer.sv
// conversion result storage, one write and one asynchronous read port
module result_buffer #(
	parameter int DEPTH = 16,
	parameter int W = 12
)
(
	input wire logic clk, // system clock
	input wire logic we, // write strobe
	input wire logic [$clog2(DEPTH)-1:0] waddr, // write entry
	input wire logic [W-1:0] wdata, // right-justified result
	input wire logic [$clog2(DEPTH)-1:0] raddr, // read entry
	output logic [W-1:0] rdata // stored result
);
	// no reset on purpose: contents survive a reset, unknown at power-on
	logic [W-1:0] mem [DEPTH];

	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	assign rdata = mem[raddr];
endmodule

// ===== bench/pin_model.sv
// behavioural model of the analog port pins feeding the converter
module pin_model
(
	input wire logic [3:0] chan, // selected pin number
	input wire logic [15:0] level, // digital levels on the pins
	output logic [15:0] pin_in, // levels seen by the port
	output logic [11:0] ana_code // code of the selected analog level
);
	timeunit 1ns;
	timeprecision 1ns;
	// each channel yields a distinct analog code so a wrong channel shows up
	assign pin_in = level;
	assign ana_code = {chan, chan, 4'hC};
endmodule

// ===== bench/testbench.sv
// self-checking bench for the converter control block
`include "adc_fmt_consts.svh"
module testbench;
timeunit 1ns;
timeprecision 1ns;
logic aclk = 0;
logic aresetn = 0;
logic [7:0] awaddr = 8'h00;
logic [7:0] araddr = 8'h00;
logic awvalid = 0;
logic wvalid = 0;
logic bready = 0;
logic arvalid = 0;
logic rready = 0;
logic cpu_idle = 0;
logic [31:0] wdata = 32'h00000000;
logic [3:0] wstrb = 4'hF;
logic [15:0] pin_out = 16'h0000;
logic [15:0] level = 16'h0000;
logic [3:0] chan = 4'h0;
logic awready, wready, bvalid, arready, rvalid, conv_active;
logic [1:0] bresp, rresp;
logic [31:0] rdata;
logic [15:0] pin_in;
logic [11:0] ana_code;
int failures = 0;
int checks_done = 0;
int n1, n2;
// short sequence keeps the run brief; timing checks use the same figure
localparam int CONV_N = 2;
initial forever #50 aclk = ~aclk;
pin_model pin_model_i (.chan(chan), .level(level), .pin_in(pin_in),
	.ana_code(ana_code));
adc_fmt_ctrl #(.CONV_CYCLES(CONV_N)) adc_fmt_ctrl_i (.aclk(aclk),
	.aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
	.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
	.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rresp(rresp), .rvalid(rvalid), .rready(rready), .cpu_idle(cpu_idle),
	.pin_in(pin_in), .pin_out(pin_out), .ana_code(ana_code),
	.conv_active(conv_active));
// ****************************************
// checking and bus tasks
// ****************************************
task close_out;
	$display("checks %0d failures %0d", checks_done, failures);
	if (failures == 0 && checks_done > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
endtask
task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
	checks_done++;
	if (g !== e)
	begin
		failures++;
		$display("[FAIL] %s expected %h seen %h", nm, e, g);
	end
endtask
task hang(input string nm);
	chk(nm, 32'h00000000, 32'h00000001);
	close_out();
endtask
task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
	int i;
	@(posedge aclk);
	awaddr <= a;
	wdata <= d;
	awvalid <= 1'b1;
	wvalid <= 1'b1;
	bready <= 1'b1;
	for (i = 0; i < 50; i++)
	begin
		@(posedge aclk);
		if (awvalid && awready === 1'b1)
			awvalid <= 1'b0;
		if (wvalid && wready === 1'b1)
			wvalid <= 1'b0;
		if (bvalid === 1'b1)
			break;
	end
	if (i == 50)
		hang("write wait");
	r = bresp;
	bready <= 1'b0;
endtask
task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
	int i;
	@(posedge aclk);
	araddr <= a;
	arvalid <= 1'b1;
	rready <= 1'b1;
	for (i = 0; i < 50; i++)
	begin
		@(posedge aclk);
		if (arvalid && arready === 1'b1)
			arvalid <= 1'b0;
		if (rvalid === 1'b1)
			break;
	end
	if (i == 50)
		hang("read wait");
	d = rdata;
	r = rresp;
	rready <= 1'b0;
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
	logic [1:0] r;
	axw(a, d, r);
	chk("bresp", `RESP_OKAY, r);
endtask
task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
	logic [31:0] d;
	logic [1:0] r;
	axr(a, d, r);
	chk(nm, e, d);
	chk("rresp", `RESP_OKAY, r);
endtask
task wait_conv(output int n);
	int i;
	n = 0;
	for (i = 0; i < 20 && conv_active !== 1'b1; i++)
		@(posedge aclk);
	while (conv_active === 1'b1 && n < 300)
	begin
		@(posedge aclk);
		n++;
	end
	if (n == 0 || n == 300)
		hang("conversion wait");
endtask
task do_reset;
	@(posedge aclk);
	aresetn <= 1'b0;
	repeat (2) @(posedge aclk);
	aresetn <= 1'b1;
endtask
// ****************************************
// scenarios
// ****************************************
task t_reset_vals;
	logic [31:0] d;
	logic [1:0] r;
	rdc("ctrl", `CTRL_OFF, 32'h00000000);
	rdc("chsel", `CHSEL_OFF, 32'h00000000);
	rdc("pincfg", `PINCFG_OFF, 32'h00000000);
	rdc("dir", `DIR_OFF, 32'h0000FFFF);
	axw(8'h30, 32'hFFFFFFFF, r);
	chk("unmapped bresp", `RESP_SLVERR, r);
	axr(8'h30, d, r);
	chk("unmapped rresp", `RESP_SLVERR, r);
	chk("unmapped rdata", 32'h00000000, d);
endtask
task t_formats;
	logic [31:0] e [4];
	int f;
	e = '{32'h000009A5, 32'h0000F9A5, 32'h00009A50, 32'h00009A50};
	wr(8'h54, 32'hFFFFF9A5);
	wr(8'h58, 32'h000005A5);
	for (f = 0; f < 4; f++)
	begin
		wr(`CTRL_OFF, f << `CTRL_FMT_LSB);
		rdc("entry5", 8'h54, e[f]);
	end
	wr(`CTRL_OFF, 32'h00000004);
	rdc("entry6 sint", 8'h58, 32'h000005A5);
	wr(`CTRL_OFF, 32'h00000000);
endtask
task t_port;
	level <= 16'hA5C3;
	wr(`PINCFG_OFF, 32'h000000FF);
	rdc("port", `PORT_OFF, 32'h000000C3);
	wr(`PINCFG_OFF, 32'h00000000);
endtask
task t_convert;
	logic [31:0] d;
	logic [1:0] r;
	int i;
	chan <= 4'h3;
	wr(`CHSEL_OFF, 32'h00000003);
	wr(`CTRL_OFF, 32'h00000011);
	wait_conv(n1);
	rdc("analog result", 8'h40, 32'h0000033C);
	axr(`STAT_OFF, d, r);
	chk("done", 32'h1, d[`STAT_DONE_BIT]);
	// output pin, other select field and direction must not alter timing
	pin_out <= 16'h0008;
	wr(`DIR_OFF, 32'h0000FFF7);
	wr(`CHSEL_OFF, 32'h000000F3);
	wr(`CTRL_OFF, 32'h00000011);
	wait_conv(n2);
	chk("sequence length", n1, n2);
	chk("sequence cycles", CONV_N, n1);
	rdc("driven level", 8'h44, 32'h00000FFF);
	wr(8'h48, 32'h00000123);
	wr(`PINCFG_OFF, 32'h00000008);
	wr(`CTRL_OFF, 32'h00000011);
	for (i = 0; i < 20; i++)
	begin
		axr(`STAT_OFF, d, r);
		if (d[`STAT_SKIP_BIT] === 1'b1)
			break;
	end
	chk("skipped", 32'h1, d[`STAT_SKIP_BIT]);
	rdc("entry2 kept", 8'h48, 32'h00000123);
	wr(`STAT_OFF, 32'h00000006);
	axr(`STAT_OFF, d, r);
	chk("done cleared", 32'h0, d[`STAT_DONE_BIT]);
	chk("skip cleared", 32'h0, d[`STAT_SKIP_BIT]);
	wr(`PINCFG_OFF, 32'h00000000);
endtask
task t_idle_reset;
	logic [31:0] d;
	logic [1:0] r;
	cpu_idle <= 1'b1;
	wr(`CTRL_OFF, 32'h00000011);
	wait_conv(n2);
	chk("runs in idle", n1, n2);
	wr(`CTRL_OFF, 32'h00000013);
	repeat (20) @(posedge aclk);
	chk("halted active", 32'h1, conv_active);
	axr(`STAT_OFF, d, r);
	chk("halt flag", 32'h1, d[`STAT_HALT_BIT]);
	do_reset();
	cpu_idle <= 1'b0;
	@(posedge aclk);
	chk("aborted", 32'h0, conv_active);
	rdc("ctrl after reset", `CTRL_OFF, 32'h00000000);
	rdc("entry0 kept", 8'h40, 32'h0000033C);
	rdc("entry1 kept", 8'h44, 32'h00000FFF);
	// switching off a frozen sequence must end it without a result
	cpu_idle <= 1'b1;
	wr(`CTRL_OFF, 32'h00000013);
	repeat (5) @(posedge aclk);
	chk("halted again", 32'h1, conv_active);
	wr(`CTRL_OFF, 32'h00000000);
	@(posedge aclk);
	chk("switched off", 32'h0, conv_active);
	axr(`STAT_OFF, d, r);
	chk("no done on abort", 32'h0, d[`STAT_DONE_BIT]);
	cpu_idle <= 1'b0;
endtask
initial
begin
	repeat (2) @(posedge aclk);
	aresetn <= 1'b1;
	t_reset_vals();
	t_formats();
	t_port();
	t_convert();
	t_idle_reset();
	close_out();
end
endmodule
